// *** core/osd_pkg.sv ***
// constants, codes and types shared by the posture and jolt detector
// Behaviour
// RQ1 - settled posture code: up, cw, inverted, ccw
// RQ2 - classify by signs of x-y and x+y
// RQ3 - drop sample when both magnitudes below 3/8g
// RQ4 - settle only after consecutive identical new posture
// RQ5 - settle period 160, 320, 640, 1280 ms
// RQ6 - instant posture follows every valid sample
// RQ7 - weak flag set invalid, cleared valid, each cycle
// RQ8 - jolt axis x for 01/11, y otherwise
// RQ9 - start jolt above threshold, keep its sign
// RQ10 - threshold 0.5, 1.0, 1.5, 2.0 g
// RQ11 - mode 0 opposite over threshold, 1 reversal
// RQ12 - second event inside 80..640 ms window
// RQ13 - jolt code none, left, right; never 11
// RQ14 - jolt direction from the event signs
// RQ15 - event pin high while event flag set
// RQ16 - event flag on posture change or jolt
// RQ17 - status read clears event flag and pin
// RQ18 - no new jolt until status read serviced
// RQ19 - host answers event pin by reading status
// RQ20 - power-off bit stops detection
// RQ21 - config byte layout power/mode/thr/window/settle
// RQ22 - status byte layout event/jolt/weak/inst/settled
// RQ23 - samples are 8-bit two's complement
// RQ24 - pointer loaded by first byte, auto-increments
// RQ25 - timing counted in fixed measurement cycles
// RQ26 - negative first event left, positive right
package osd_pkg;

  // ----------------------------------------------------------
  // clock and measurement cycle
  // ----------------------------------------------------------
  localparam int CLK_FREQ_MHZ = 200;
  localparam int MEAS_PERIOD_MS = 10;
  localparam int MEAS_CYCLES = MEAS_PERIOD_MS * 1000 * 1000 * CLK_FREQ_MHZ / 1000;

  // ----------------------------------------------------------
  // settle and window times, counted in measurement cycles
  // ----------------------------------------------------------
  localparam int SETTLE_MS_0 = 160;
  localparam int SETTLE_MS_1 = 320;
  localparam int SETTLE_MS_2 = 640;
  localparam int SETTLE_MS_3 = 1280;
  localparam int WINDOW_MS_0 = 80;
  localparam int WINDOW_MS_1 = 160;
  localparam int WINDOW_MS_2 = 320;
  localparam int WINDOW_MS_3 = 640;
  localparam logic [3:0][7:0] SETTLE_COUNTS = {
    8'(SETTLE_MS_3 / MEAS_PERIOD_MS), 8'(SETTLE_MS_2 / MEAS_PERIOD_MS),
    8'(SETTLE_MS_1 / MEAS_PERIOD_MS), 8'(SETTLE_MS_0 / MEAS_PERIOD_MS)};
  localparam logic [3:0][7:0] WINDOW_COUNTS = {
    8'(WINDOW_MS_3 / MEAS_PERIOD_MS), 8'(WINDOW_MS_2 / MEAS_PERIOD_MS),
    8'(WINDOW_MS_1 / MEAS_PERIOD_MS), 8'(WINDOW_MS_0 / MEAS_PERIOD_MS)};

  // ----------------------------------------------------------
  // acceleration scaling: 8-bit sample spans +-2 g
  // ----------------------------------------------------------
  localparam int COUNTS_PER_G = 64;
  localparam logic [7:0] WEAK_LIMIT = 8'(3 * COUNTS_PER_G / 8);
  localparam logic [3:0][7:0] JOLT_THR_COUNTS = {
    8'(4 * COUNTS_PER_G / 2), 8'(3 * COUNTS_PER_G / 2),
    8'(2 * COUNTS_PER_G / 2), 8'(1 * COUNTS_PER_G / 2)};

  // ----------------------------------------------------------
  // register offsets and reset values
  // ----------------------------------------------------------
  localparam logic [7:0] REG_XSAMPLE = 8'h00;
  localparam logic [7:0] REG_YSAMPLE = 8'h01;
  localparam logic [7:0] REG_STATUS = 8'h02;
  localparam logic [7:0] REG_CONFIG = 8'h04;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] POINTER_RESET = 8'h00;

  // ----------------------------------------------------------
  // field positions
  // ----------------------------------------------------------
  localparam int CFG_POWER_OFF = 7;
  localparam int CFG_JOLT_MODE = 6;
  localparam int CFG_JOLT_THR_LSB = 4;
  localparam int CFG_JOLT_WIN_LSB = 2;
  localparam int CFG_SETTLE_LSB = 0;

  // ----------------------------------------------------------
  // codes and types
  // ----------------------------------------------------------
  localparam logic [1:0] POSTURE_UP = 2'h0;
  localparam logic [1:0] POSTURE_CW = 2'h1;
  localparam logic [1:0] POSTURE_DOWN = 2'h2;
  localparam logic [1:0] POSTURE_CCW = 2'h3;
  localparam logic [1:0] JOLT_NONE = 2'h0;
  localparam logic [1:0] JOLT_LEFT = 2'h1;
  localparam logic [1:0] JOLT_RIGHT = 2'h2;

  typedef enum logic [2:0] {
    JOLT_IDLE = 3'h1,
    JOLT_ARMED = 3'h2,
    JOLT_HOLD = 3'h4
  } osd_jolt_state_t;

endpackage

// *** core/osd_posture_classify.sv ***
// posture classifier for one latched x/y sample pair
module osd_posture_classify (
  input wire logic signed [7:0] accelX,
  input wire logic signed [7:0] accelY,
  output logic [1:0] postureCode,
  output logic postureValid
);

  // ----------------------------------------------------------
  // sign of difference and sum, widened so nothing wraps
  // ----------------------------------------------------------
  logic signed [8:0] diffXY;
  logic signed [8:0] sumXY;
  logic [7:0] magX;
  logic [7:0] magY;

  assign diffXY = 9'(accelX) - 9'(accelY);
  assign sumXY = 9'(accelX) + 9'(accelY);

  // quadrant from the two diagonal signs
  assign postureCode = !sumXY[8] && diffXY[8] ? osd_pkg::POSTURE_UP :  // RQ2
    !sumXY[8] ? osd_pkg::POSTURE_CW :
    !diffXY[8] ? osd_pkg::POSTURE_DOWN :
    osd_pkg::POSTURE_CCW;

  // -128 folds to 8'h80, which still compares correctly unsigned
  assign magX = accelX[7] ? ~accelX + 8'h01 : accelX;
  assign magY = accelY[7] ? ~accelY + 8'h01 : accelY;

  // free fall or flat: too little signal on both axes
  assign postureValid = (magX >= osd_pkg::WEAK_LIMIT) ||
    (magY >= osd_pkg::WEAK_LIMIT);  // RQ3

endmodule

// *** core/orientation_shake_detector.sv ***
// posture and jolt detector with byte register port
module orientation_shake_detector #(
  parameter int unsigned MEAS_CYCLES = osd_pkg::MEAS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic signed [7:0] accelX,
  input wire logic signed [7:0] accelY,
  input wire logic hostWrite,
  input wire logic hostWriteFirst,
  input wire logic [7:0] hostWriteData,
  input wire logic hostRead,
  output logic [7:0] hostReadData,
  output logic eventPin,
  output logic powerOff
);

  localparam int MW = $clog2(MEAS_CYCLES + 1);

  // ----------------------------------------------------------
  // declarations
  // ----------------------------------------------------------
  logic [MW-1:0] measCnt_reg;
  logic sampleTick;
  logic evalPulse_reg;
  logic signed [7:0] xLatch_reg;
  logic signed [7:0] yLatch_reg;
  logic [7:0] config_reg;
  logic [7:0] pointer_reg;
  logic [7:0] pointer_next;
  logic [7:0] readData_reg;
  logic [7:0] readMux;
  logic [7:0] statusByte;
  logic statusRead;
  logic configWrite;
  logic eventFlag_reg;
  logic eventFlag_next;
  logic setEvent;
  logic weakFlag_reg;
  logic [1:0] instant_reg;
  logic [1:0] settled_reg;
  logic [1:0] settled_next;
  logic [1:0] cand_reg;
  logic [1:0] cand_next;
  logic [7:0] settleCnt_reg;
  logic [7:0] settleCnt_next;
  logic [7:0] settleLimit;
  logic settleDone;
  logic [1:0] postureNow;
  logic postureValid;
  logic validEval;
  osd_pkg::osd_jolt_state_t joltState_reg;
  osd_pkg::osd_jolt_state_t joltState_next;
  logic [7:0] winCnt_reg;
  logic [7:0] winCnt_next;
  logic [7:0] winLimit;
  logic firstNeg_reg;
  logic firstNeg_next;
  logic [1:0] joltCode_reg;
  logic [1:0] joltCode_next;
  logic joltEvent;
  logic signed [7:0] perp;
  logic perpNeg;
  logic [7:0] perpMag;
  logic [7:0] joltThr;
  logic overThr;
  logic secondHit;
  logic joltMode;

  // ----------------------------------------------------------
  // configuration fields
  // ----------------------------------------------------------
  // field decode straight off the write-only byte
  assign joltMode = config_reg[osd_pkg::CFG_JOLT_MODE];  // RQ21
  assign settleLimit = osd_pkg::SETTLE_COUNTS[
    config_reg[osd_pkg::CFG_SETTLE_LSB +: 2]];  // RQ5
  assign winLimit = osd_pkg::WINDOW_COUNTS[
    config_reg[osd_pkg::CFG_JOLT_WIN_LSB +: 2]];  // RQ12
  assign joltThr = osd_pkg::JOLT_THR_COUNTS[
    config_reg[osd_pkg::CFG_JOLT_THR_LSB +: 2]];  // RQ10

  // ----------------------------------------------------------
  // measurement cycle timer
  // ----------------------------------------------------------
  // all settle and window timing is counted in these ticks;
  // the timer is held at zero while powered off so detection stops
  assign sampleTick = (measCnt_reg == MW'(MEAS_CYCLES - 1)) &&
    !config_reg[osd_pkg::CFG_POWER_OFF];  // RQ20

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      measCnt_reg <= '0;
    end else if (config_reg[osd_pkg::CFG_POWER_OFF]) begin
      measCnt_reg <= '0;  // RQ20
    end else if (sampleTick) begin
      measCnt_reg <= '0;  // RQ25
    end else begin
      measCnt_reg <= measCnt_reg + 1'b1;
    end
  end

  // sample snapshot; evaluation runs one cycle later on it
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      xLatch_reg <= 8'h00;
      yLatch_reg <= 8'h00;
      evalPulse_reg <= 1'b0;
    end else begin
      evalPulse_reg <= sampleTick;
      if (sampleTick) begin
        xLatch_reg <= accelX;  // RQ23
        yLatch_reg <= accelY;
      end
    end
  end

  // ----------------------------------------------------------
  // posture classification
  // ----------------------------------------------------------
  osd_posture_classify classify (
    .accelX(xLatch_reg),
    .accelY(yLatch_reg),
    .postureCode(postureNow),
    .postureValid(postureValid)
  );

  assign validEval = evalPulse_reg && postureValid;

  // ----------------------------------------------------------
  // posture settle filter
  // ----------------------------------------------------------
  // invalid samples are skipped, not counted as a break, so a
  // brief weak patch does not restart a nearly finished settle
  assign settleDone = ({1'b0, settleCnt_reg} + 9'h001) >= {1'b0, settleLimit};

  always_comb begin
    settled_next = settled_reg;
    cand_next = cand_reg;
    settleCnt_next = settleCnt_reg;
    if (validEval) begin
      if (postureNow == settled_reg) begin
        cand_next = settled_reg;
        settleCnt_next = 8'h00;
      end else if (postureNow == cand_reg) begin
        if (settleDone) begin
          settled_next = postureNow;  // RQ4
          settleCnt_next = 8'h00;
        end else begin
          settleCnt_next = settleCnt_reg + 8'h01;  // RQ4
        end
      end else begin
        cand_next = postureNow;  // RQ4
        settleCnt_next = 8'h01;
      end
    end
  end

  // instant posture follows every valid evaluation, weak flag every evaluation
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      settled_reg <= osd_pkg::POSTURE_UP;
      cand_reg <= osd_pkg::POSTURE_UP;
      settleCnt_reg <= 8'h00;
      instant_reg <= osd_pkg::POSTURE_UP;
      weakFlag_reg <= 1'b0;
    end else begin
      settled_reg <= settled_next;  // RQ1
      cand_reg <= cand_next;
      settleCnt_reg <= settleCnt_next;
      if (validEval) begin
        instant_reg <= postureNow;  // RQ6
      end
      if (evalPulse_reg) begin
        weakFlag_reg <= !postureValid;  // RQ7
      end
    end
  end

  // ----------------------------------------------------------
  // jolt detection
  // ----------------------------------------------------------
  // the axis along the settled posture (the one it is classified on) carries the jolt
  assign perp = settled_reg[0] ? xLatch_reg : yLatch_reg;  // RQ8
  assign perpNeg = perp[7];
  assign perpMag = perpNeg ? ~perp + 8'h01 : perp;
  assign overThr = perpMag > joltThr;  // RQ9
  // mode 1 only needs the sign to flip; mode 0 also the threshold
  assign secondHit = (perpNeg != firstNeg_reg) && (joltMode || overThr);  // RQ11

  always_comb begin
    joltState_next = joltState_reg;
    winCnt_next = winCnt_reg;
    firstNeg_next = firstNeg_reg;
    joltCode_next = joltCode_reg;
    joltEvent = 1'b0;
    if (statusRead) begin
      joltCode_next = osd_pkg::JOLT_NONE;
    end
    unique case (joltState_reg)
      osd_pkg::JOLT_IDLE: begin
        if (evalPulse_reg && overThr) begin
          joltState_next = osd_pkg::JOLT_ARMED;  // RQ9
          firstNeg_next = perpNeg;  // RQ9
          winCnt_next = 8'h00;
        end
      end
      osd_pkg::JOLT_ARMED: begin
        if (config_reg[osd_pkg::CFG_POWER_OFF]) begin
          joltState_next = osd_pkg::JOLT_IDLE;  // RQ20
        end else if (evalPulse_reg && secondHit) begin
          joltState_next = osd_pkg::JOLT_HOLD;
          joltEvent = 1'b1;
          // negative lead reads as left; 11 is never formed
          joltCode_next = firstNeg_reg ? osd_pkg::JOLT_LEFT :
            osd_pkg::JOLT_RIGHT;  // RQ14 RQ26 RQ13
        end else if (evalPulse_reg) begin
          if (({1'b0, winCnt_reg} + 9'h001) >= {1'b0, winLimit}) begin
            joltState_next = osd_pkg::JOLT_IDLE;  // RQ12
          end else begin
            winCnt_next = winCnt_reg + 8'h01;  // RQ12
          end
        end
      end
      osd_pkg::JOLT_HOLD: begin
        // blocked until the host services the pending event
        if (statusRead) begin
          joltState_next = osd_pkg::JOLT_IDLE;  // RQ18
        end
      end
      default: begin
        joltState_next = osd_pkg::JOLT_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      joltState_reg <= osd_pkg::JOLT_IDLE;
      winCnt_reg <= 8'h00;
      firstNeg_reg <= 1'b0;
      joltCode_reg <= osd_pkg::JOLT_NONE;
    end else begin
      joltState_reg <= joltState_next;
      winCnt_reg <= winCnt_next;
      firstNeg_reg <= firstNeg_next;
      joltCode_reg <= joltCode_next;
    end
  end

  // ----------------------------------------------------------
  // event flag
  // ----------------------------------------------------------
  // a new event in the read cycle wins over the clear, so the
  // host never loses one between the read and the clear
  assign setEvent = joltEvent || (settled_next != settled_reg);  // RQ16
  assign eventFlag_next = setEvent ? 1'b1 :
    statusRead ? 1'b0 : eventFlag_reg;  // RQ17 RQ19

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      eventFlag_reg <= 1'b0;
    end else begin
      eventFlag_reg <= eventFlag_next;
    end
  end

  // ----------------------------------------------------------
  // register port
  // ----------------------------------------------------------
  assign statusByte = {eventFlag_reg, joltCode_reg, weakFlag_reg,
    instant_reg, settled_reg};  // RQ22
  assign statusRead = hostRead && (pointer_reg == osd_pkg::REG_STATUS);  // RQ17
  assign configWrite = hostWrite && !hostWriteFirst &&
    (pointer_reg == osd_pkg::REG_CONFIG);  // RQ21

  // config is write-only and reads back as zero, like holes
  assign readMux = (pointer_reg == osd_pkg::REG_XSAMPLE) ? xLatch_reg :
    (pointer_reg == osd_pkg::REG_YSAMPLE) ? yLatch_reg :
    (pointer_reg == osd_pkg::REG_STATUS) ? statusByte : 8'h00;

  // first written byte loads the pointer, data bytes step it
  assign pointer_next = (hostWrite && hostWriteFirst) ? hostWriteData :
    (hostWrite || hostRead) ? pointer_reg + 8'h01 : pointer_reg;  // RQ24

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pointer_reg <= osd_pkg::POINTER_RESET;
      config_reg <= osd_pkg::CONFIG_RESET;
      readData_reg <= 8'h00;
    end else begin
      pointer_reg <= pointer_next;  // RQ24
      if (configWrite) begin
        config_reg <= hostWriteData;  // RQ21
      end
      if (hostRead) begin
        readData_reg <= readMux;
      end
    end
  end

  // ----------------------------------------------------------
  // outputs, each the q of a flop above
  // ----------------------------------------------------------
  assign hostReadData = readData_reg;
  assign eventPin = eventFlag_reg;  // RQ15
  assign powerOff = config_reg[osd_pkg::CFG_POWER_OFF];  // RQ20

endmodule

// *** tb/osd_monitor.sv ***
// assertion checker bound to the posture and jolt detector ports
module osd_monitor #(
  parameter int unsigned MEAS_CYCLES = osd_pkg::MEAS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hostWrite,
  input wire logic hostWriteFirst,
  input wire logic [7:0] hostWriteData,
  input wire logic hostRead,
  input wire logic [7:0] hostReadData,
  input wire logic eventPin,
  input wire logic powerOff
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------
  // pointer mirror
  // ------
  logic [7:0] ptr_reg;
  logic statusRead_reg;
  wire logic cfgWrite = hostWrite && !hostWriteFirst && (ptr_reg == osd_pkg::REG_CONFIG);
  wire logic statRead = hostRead && (ptr_reg == osd_pkg::REG_STATUS);
  // mirrored so status bytes can be judged without looking inside
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ptr_reg <= osd_pkg::POINTER_RESET;
      statusRead_reg <= 1'b0;
    end else begin
      statusRead_reg <= statRead;
      if (hostWrite && hostWriteFirst) begin
        ptr_reg <= hostWriteData;
      end else if (hostWrite || hostRead) begin
        ptr_reg <= ptr_reg + 8'h01;
      end
    end
  end

  default clocking mcb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence statusFetch;
    statRead;
  endsequence
  sequence cfgStore;
    cfgWrite;
  endsequence

  // ------
  // port relations
  // ------
  readHold_a: assert property (!hostRead |=> $stable(hostReadData))
    else $error("read data moved without a read");
  eventMirror_a: assert property (statusFetch |=> hostReadData[7] == $past(eventPin))
    else $error("status event bit differs from pin");
  noJoltEleven_a: assert property (statusRead_reg |-> hostReadData[6:5] != 2'h3)
    else $error("undefined jolt code reported");
  joltFlag_a: assert property (statusRead_reg && hostReadData[6:5] != 2'h0 |-> hostReadData[7])
    else $error("jolt reported without event flag");
  pinFall_a: assert property ($fell(eventPin) |-> $past(statRead))
    else $error("event pin dropped without status read");
  unmappedZero_a: assert property (hostRead && (ptr_reg == 8'h03 || ptr_reg >= 8'h04)
    |=> hostReadData == 8'h00)
    else $error("unreadable location gave data");
  powerWrite_a: assert property (cfgStore |=> powerOff == $past(hostWriteData[7]))
    else $error("power-off bit not taken from config");
  powerHold_a: assert property (!cfgWrite |=> $stable(powerOff))
    else $error("power-off moved without config write");
endmodule

bind orientation_shake_detector osd_monitor #(.MEAS_CYCLES(MEAS_CYCLES)) monitor (
  .ref_clk(ref_clk), .reset(reset), .hostWrite(hostWrite), .hostWriteFirst(hostWriteFirst),
  .hostWriteData(hostWriteData), .hostRead(hostRead), .hostReadData(hostReadData),
  .eventPin(eventPin), .powerOff(powerOff));

// *** tb/osd_host_model.sv ***
// behavioural host that writes and reads the detector registers
module osd_host_model (
  input wire logic ref_clk,
  output logic hostWrite,
  output logic hostWriteFirst,
  output logic [7:0] hostWriteData,
  output logic hostRead,
  input wire logic [7:0] hostReadData,
  input wire logic eventPin
);
  timeunit 1ns;
  timeprecision 100ps;
  // bus idle at time zero
  initial begin
    hostWrite = 1'b0;
    hostWriteFirst = 1'b0;
    hostWriteData = 8'h00;
    hostRead = 1'b0;
  end

  // first byte of a transfer loads the pointer
  task automatic put_pointer(input logic [7:0] addr);
    @(posedge ref_clk);
    hostWrite <= 1'b1;
    hostWriteFirst <= 1'b1;
    hostWriteData <= addr;
  endtask

  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    put_pointer(addr);
    @(posedge ref_clk);
    hostWriteFirst <= 1'b0;
    hostWriteData <= data;
    @(posedge ref_clk);
    hostWrite <= 1'b0;
    hostWriteData <= ~data; // released byte lane shows junk, not the last byte
    // config lands on the edge above; let it settle before callers look
    @(posedge ref_clk);
  endtask

  // gap lets the host answer slowly between pointer and fetch
  task automatic read_reg(input logic [7:0] addr, input int gap, output logic [7:0] data);
    put_pointer(addr);
    @(posedge ref_clk);
    hostWrite <= 1'b0;
    hostWriteFirst <= 1'b0;
    hostWriteData <= ~addr;
    repeat (gap) @(posedge ref_clk);
    hostRead <= 1'b1;
    @(posedge ref_clk);
    hostRead <= 1'b0;
    @(posedge ref_clk);
    data = hostReadData;
  endtask

  // answer a raised event pin by fetching status, bounded wait
  task automatic service_event(input int bound, output logic [7:0] status, output bit seen);
    seen = 1'b0;
    for (int i = 0; i < bound && !seen; i++) begin
      @(posedge ref_clk);
      seen = (eventPin === 1'b1);
    end
    read_reg(osd_pkg::REG_STATUS, 2, status);
  endtask
endmodule

// *** tb/orientation_shake_detector_test.sv ***
// self-checking bench for the posture and jolt detector
module orientation_shake_detector_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned MEAS = 4;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic signed [7:0] accelX = 8'sh00;
  logic signed [7:0] accelY = 8'sh00;
  logic hostWrite, hostWriteFirst, hostRead, eventPin, powerOff;
  logic [7:0] hostWriteData, hostReadData, st;
  int miscompares = 0;
  int n_compared = 0;
  bit seen;

  `define CHK(name, exp, got) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
    $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got); end end

  always #2.5 ref_clk = ~ref_clk;

  orientation_shake_detector #(.MEAS_CYCLES(MEAS)) dut (
    .ref_clk(ref_clk), .reset(reset), .accelX(accelX), .accelY(accelY),
    .hostWrite(hostWrite), .hostWriteFirst(hostWriteFirst), .hostWriteData(hostWriteData),
    .hostRead(hostRead), .hostReadData(hostReadData), .eventPin(eventPin),
    .powerOff(powerOff));
  osd_host_model host (
    .ref_clk(ref_clk), .hostWrite(hostWrite), .hostWriteFirst(hostWriteFirst),
    .hostWriteData(hostWriteData), .hostRead(hostRead), .hostReadData(hostReadData),
    .eventPin(eventPin));

  task automatic finish_test;
    if (miscompares == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // n ticks of one sample, plus room for evaluation and field update
  task automatic hold(input logic signed [7:0] x, input logic signed [7:0] y, input int n);
    @(posedge ref_clk);
    accelX <= x;
    accelY <= y;
    repeat (n * MEAS + 3) @(posedge ref_clk);
  endtask

  task automatic serve;
    host.service_event(400, st, seen);
    if (!seen) begin
      miscompares++;
      finish_test;
    end
  endtask

  task automatic t_reset;
    `CHK("powerOff", 1'b0, powerOff)
    host.read_reg(osd_pkg::REG_CONFIG, 0, st);
    `CHK("config read", 8'h00, st)
    host.read_reg(8'h03, 1, st);
    `CHK("gap read", 8'h00, st)
  endtask

  task automatic t_posture;
    logic signed [7:0] xs [4] = '{8'sd0, 8'sd30, 8'sd0, -8'sd30};
    logic signed [7:0] ys [4] = '{8'sd30, 8'sd0, -8'sd30, 8'sd0};
    hold(8'sd10, -8'sd10, 3);
    host.read_reg(osd_pkg::REG_STATUS, 0, st);
    `CHK("weak status", 8'h10, st)
    for (int i = 0; i < 4; i++) begin
      hold(xs[i], ys[i], 3);
      host.read_reg(osd_pkg::REG_STATUS, 0, st);
      `CHK("instant posture", 8'(i * 4), st)
    end
    hold(8'sd30, 8'sd0, 12);
    host.read_reg(osd_pkg::REG_STATUS, 0, st);
    `CHK("not yet settled", 8'h04, st)
    hold(8'sd30, 8'sd0, 8);
    serve();
    `CHK("settled cw", 8'h85, st)
    `CHK("pin released", 1'b0, eventPin)
  endtask

  // settled cw: jolt uses x
  task automatic t_jolt;
    hold(8'sd40, 8'sd0, 2);
    hold(-8'sd40, 8'sd0, 2);
    hold(8'sd40, 8'sd0, 2);
    `CHK("jolt pin", 1'b1, eventPin)
    host.read_reg(osd_pkg::REG_STATUS, 0, st);
    `CHK("jolt right held", 8'hC5, st)
    host.read_reg(osd_pkg::REG_STATUS, 0, st);
    `CHK("jolt cleared", 8'h05, st)
    hold(8'sd40, 8'sd0, 2);
    hold(-8'sd1, -8'sd30, 10);
    host.read_reg(osd_pkg::REG_STATUS, 0, st);
    `CHK("mode0 no jolt", 8'h09, st)
    host.write_reg(osd_pkg::REG_CONFIG, 8'h40);
    hold(-8'sd40, 8'sd0, 2);
    hold(8'sd5, 8'sd30, 2);
    host.read_reg(osd_pkg::REG_STATUS, 0, st);
    `CHK("mode1 jolt left", 8'hA1, st)
    hold(8'sd40, 8'sd0, 2);
    hold(8'sd10, 8'sd30, 9);
    hold(-8'sd10, 8'sd30, 1);
    host.read_reg(osd_pkg::REG_STATUS, 0, st);
    `CHK("late reversal", 8'h01, st)
  endtask

  task automatic t_power;
    host.write_reg(osd_pkg::REG_CONFIG, 8'h80);
    `CHK("powerOff set", 1'b1, powerOff)
    hold(8'sd0, -8'sd30, 20);
    host.read_reg(osd_pkg::REG_STATUS, 0, st);
    `CHK("frozen status", 8'h01, st)
    host.write_reg(osd_pkg::REG_CONFIG, 8'h00);
    hold(8'sd0, -8'sd30, 20);
    serve();
    `CHK("settled down", 8'h8A, st)
    host.write_reg(osd_pkg::REG_CONFIG, 8'h10);
    hold(8'sd0, 8'sd50, 2);
    hold(8'sd0, -8'sd50, 2);
    host.read_reg(osd_pkg::REG_STATUS, 0, st);
    `CHK("below 1g threshold", 8'h0A, st)
    host.read_reg(osd_pkg::REG_YSAMPLE, 0, st);
    `CHK("y sample", 8'hCE, st)
  endtask

  // main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_posture();
    t_jolt();
    t_power();
    finish_test();
  end

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    finish_test();
  end
endmodule
